/* hdl/ipd_pkg.sv */
package ipd_pkg;

    // special register addresses
    localparam logic [31:0] IPD_ADDR_PHYS_ID = 32'h0000_0802;
    localparam logic [31:0] IPD_ADDR_LDR     = 32'h0000_080d;
    localparam logic [31:0] IPD_ADDR_ICR     = 32'h0000_0830;

    // identification leaves and fields
    localparam logic [31:0] IPD_LEAF_MAX      = 32'h0000_0000;
    localparam logic [31:0] IPD_LEAF_FEATURE  = 32'h0000_0001;
    localparam logic [31:0] IPD_LEAF_TOPO     = 32'h0000_000b;
    localparam logic [31:0] IPD_MAX_BASIC     = 32'h0000_000b;
    localparam int          IPD_FEAT_EXT_BIT  = 21;
    localparam int          IPD_INIT_ID_LSB   = 24;
    localparam logic [7:0]  IPD_SUB_SMT       = 8'h00;
    localparam logic [7:0]  IPD_SUB_CORE      = 8'h01;
    localparam logic [7:0]  IPD_LVL_SMT       = 8'h01;
    localparam logic [7:0]  IPD_LVL_CORE      = 8'h02;
    localparam logic [4:0]  IPD_SMT_SHIFT     = 5'h01;
    localparam logic [4:0]  IPD_CORE_SHIFT    = 5'h05;
    localparam logic [15:0] IPD_SMT_COUNT     = 16'h0002;
    localparam logic [15:0] IPD_CORE_COUNT    = 16'h0008;

    // logical id layout
    localparam int          IPD_LDR_CLUSTER_LSB  = 16;
    localparam int          IPD_PHYS_CLUSTER_LSB = 4;
    localparam logic [15:0] IPD_CLUSTER_IMPL     = 16'hffff;
    localparam logic [15:0] IPD_LOGICAL_IMPL     = 16'hffff;
    localparam logic [31:0] IPD_BROADCAST_ID     = 32'hffff_ffff;

    // command register low half: writable bits, status bit absent
    localparam logic [31:0] IPD_ICR_LOW_MASK = 32'h000c_cfff;

    // strap settle cycles after reset release
    localparam logic [1:0]  IPD_STRAP_WAIT = 2'h2;

    typedef enum logic [1:0] {
        IPD_MODE_OFF    = 2'b00,
        IPD_MODE_LEGACY = 2'b01,
        IPD_MODE_EXT    = 2'b11
    } ipd_mode_type;

    typedef struct packed {
        logic [11:0] rsvd_hi;
        logic [1:0]  shorthand;
        logic [1:0]  rsvd_mid;
        logic        trigger;
        logic        level;
        logic        rsvd_lo;
        logic        no_status;
        logic        dest_logical;
        logic [2:0]  delivery;
        logic [7:0]  vector;
    } ipd_icr_low_type;

    typedef struct packed {
        logic [31:0]     dest;
        ipd_icr_low_type low;
        logic            broadcast;
    } ipd_ipi_type;

    typedef struct packed {
        logic [31:0] eax;
        logic [31:0] ebx;
        logic [31:0] ecx;
        logic [31:0] edx;
    } ipd_id_resp_type;

endpackage

/* hdl/ipd_ipi_dest.sv */
`timescale 1ns/1ps
// How it works
// (RL1) feature leaf ECX bit 21 reports extended mode
// (RL2) topology leaf EDX returns full 32-bit id
// (RL3) initial 8-bit id equals topology EDX low byte
// (RL4) register 802H matches topology leaf EDX value
// (RL5) command low half legacy layout, no status bit
// (RL6) command destination field is 32 bits wide
// (RL7) one command write dispatches the interrupt
// (RL8) command readback is debug only, not guaranteed
// (RL9) all-ones destination means broadcast to everyone
// (RL10) logical register 32 bits, read-only to software
// (RL11) read at 80DH returns logical register
// (RL12) no flat mode, no destination format register
// (RL13) cluster in bits 31:16, logical in 15:0
// (RL14) unimplemented logical register bits read zero
// (RL15) logical = 1 << id[3:0], cluster = id[19:4]
// (RL16) logical register reloads when extended mode enters
// (RL17) legacy handoff only if all ids below 255
// (RL18) firmware parks processors with id 255 or more
// (RL19) topology leaf valid: max leaf >= 0BH, EBX nonzero
// (RL20) logical accept: cluster equal and bits overlap
module ipd_ipi_dest
    import ipd_pkg::*;
(
    // clock, reset, enable
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire logic            clk_en,
    // base register state bits
    input  wire logic            base_enable,
    input  wire logic            base_extended,
    // physical id strap pins
    input  wire logic [31:0]     phys_id_pin,
    // identification instruction
    input  wire logic            id_req,
    input  wire logic [31:0]     id_leaf,
    input  wire logic [31:0]     id_subleaf,
    output ipd_id_resp_type      id_resp,
    output logic                 id_resp_valid,
    // special register access
    input  wire logic            sr_rd,
    input  wire logic            sr_wr,
    input  wire logic [31:0]     sr_addr,
    input  wire logic [63:0]     sr_wdata,
    output logic [63:0]          sr_rdata,
    output logic                 sr_done,
    output logic                 sr_fault,
    // outgoing interrupt message
    output logic                 ipi_send,
    output ipd_ipi_type          ipi_msg,
    // incoming destination check
    input  wire logic            rx_valid,
    input  wire logic            rx_logical,
    input  wire logic [31:0]     rx_dest,
    output logic                 rx_done,
    output logic                 rx_accept,
    // status
    output ipd_mode_type         mode_state,
    output logic [31:0]          phys_id_out
);

    // derive logical id from physical id, unimplemented bits cleared
    function automatic logic [31:0] ipd_derive_ldr(input logic [31:0] pid);
        logic [15:0] cluster;
        logic [15:0] logical;
        cluster = pid[IPD_PHYS_CLUSTER_LSB +: 16] & IPD_CLUSTER_IMPL;
        logical = (16'h0001 << pid[3:0]) & IPD_LOGICAL_IMPL;
        return {cluster, logical};
    endfunction

    // base register state bits to controller mode
    function automatic ipd_mode_type ipd_mode_step(input ipd_mode_type cur,
                                                   input logic en,
                                                   input logic ext);
        ipd_mode_type nxt;
        nxt = cur;
        unique case (cur)
            IPD_MODE_OFF: begin
                if (en && !ext)
                    nxt = IPD_MODE_LEGACY;
            end
            IPD_MODE_LEGACY: begin
                if (en && ext)
                    nxt = IPD_MODE_EXT;
                else if (!en && !ext)
                    nxt = IPD_MODE_OFF;
            end
            IPD_MODE_EXT: begin
                if (!en && !ext)
                    nxt = IPD_MODE_OFF;
            end
            default: nxt = IPD_MODE_LEGACY;
        endcase
        return nxt;
    endfunction

    // answer for one identification request
    function automatic ipd_id_resp_type ipd_id_answer(input logic [31:0] leaf,
                                                      input logic [31:0] sub,
                                                      input logic [31:0] pid);
        ipd_id_resp_type r;
        r = '0;
        if (leaf == IPD_LEAF_MAX) begin
            r.eax = IPD_MAX_BASIC;
        end else if (leaf == IPD_LEAF_FEATURE) begin
            r.ecx[IPD_FEAT_EXT_BIT] = 1'b1;
            r.ebx[IPD_INIT_ID_LSB +: 8] = pid[7:0];
        end else if (leaf == IPD_LEAF_TOPO) begin
            r.edx = pid;
            r.ecx[7:0] = sub[7:0];
            if (sub[31:8] == 24'h000000 && sub[7:0] == IPD_SUB_SMT) begin
                r.eax[4:0]  = IPD_SMT_SHIFT;
                r.ebx[15:0] = IPD_SMT_COUNT;
                r.ecx[15:8] = IPD_LVL_SMT;
            end else if (sub[31:8] == 24'h000000 &&
                         sub[7:0] == IPD_SUB_CORE) begin
                r.eax[4:0]  = IPD_CORE_SHIFT;
                r.ebx[15:0] = IPD_CORE_COUNT;
                r.ecx[15:8] = IPD_LVL_CORE;
            end
        end
        return r;
    endfunction

    // state
    ipd_mode_type     mode_reg;
    ipd_mode_type     mode_next;
    logic [31:0]      pin_meta_reg;
    logic [31:0]      pin_sync_reg;
    logic [1:0]       strap_wait_reg;
    logic             strap_done_reg;
    logic [31:0]      phys_id_reg;
    logic [31:0]      ldr_reg;
    ipd_icr_low_type  icr_low_reg;
    logic [31:0]      icr_dest_reg;
    ipd_id_resp_type  id_resp_reg;
    logic             id_valid_reg;
    logic [63:0]      rdata_reg;
    logic             done_reg;
    logic             fault_reg;
    logic             send_reg;
    ipd_ipi_type      msg_reg;
    logic             rx_done_reg;
    logic             rx_accept_reg;

    // decode
    wire logic            in_ext;
    wire logic            enter_ext;
    wire logic            hit_phys;
    wire logic            hit_ldr;
    wire logic            hit_icr;
    wire logic            access;
    wire logic            icr_write;
    wire logic            bad_access;
    wire logic [63:0]     read_value;
    wire ipd_icr_low_type wr_low;
    wire logic            wr_bcast;
    wire logic            rx_bcast;
    wire logic            rx_phys_hit;
    wire logic            rx_log_hit;
    wire ipd_id_resp_type id_answer;

    // mode tracking and extended-mode entry edge
    assign mode_next = ipd_mode_step(mode_reg, base_enable, base_extended);
    assign in_ext    = (mode_reg == IPD_MODE_EXT);
    assign enter_ext = (mode_next == IPD_MODE_EXT) && !in_ext;

    // register decode; no flat mode so no format register is mapped
    assign hit_phys   = (sr_addr == IPD_ADDR_PHYS_ID);
    assign hit_ldr    = (sr_addr == IPD_ADDR_LDR);          // [RL11] [RL12]
    assign hit_icr    = (sr_addr == IPD_ADDR_ICR);
    assign access     = sr_rd || sr_wr;
    assign icr_write  = sr_wr && in_ext && hit_icr;          // [RL7]
    assign bad_access = !in_ext || !(hit_phys || hit_ldr || hit_icr) ||
                        (sr_wr && !hit_icr);                 // [RL10]

    // read mux; readback of command is stored value only
    assign read_value =
        hit_phys ? {32'h0000_0000, phys_id_reg} :            // [RL4]
        hit_ldr  ? {32'h0000_0000, ldr_reg} :                // [RL11]
        hit_icr  ? {icr_dest_reg, icr_low_reg} :             // [RL8]
                   64'h0000_0000_0000_0000;

    // command write fields; status and reserved bits dropped
    assign wr_low   = ipd_icr_low_type'(sr_wdata[31:0] &
                                        IPD_ICR_LOW_MASK);  // [RL5]
    assign wr_bcast = (sr_wdata[63:32] == IPD_BROADCAST_ID); // [RL9]

    // receive-side destination match
    assign rx_bcast    = (rx_dest == IPD_BROADCAST_ID);      // [RL9]
    assign rx_phys_hit = (rx_dest == phys_id_reg);
    assign rx_log_hit  =
        (rx_dest[31:IPD_LDR_CLUSTER_LSB] ==
         ldr_reg[31:IPD_LDR_CLUSTER_LSB]) &&
        |(rx_dest[IPD_LDR_CLUSTER_LSB-1:0] &
          ldr_reg[IPD_LDR_CLUSTER_LSB-1:0]);                 // [RL20] [RL13]

    // identification answer from the captured id
    assign id_answer = ipd_id_answer(id_leaf, id_subleaf,
                                     phys_id_reg);           // [RL1] [RL2]

    // strap synchroniser
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else if (clk_en) begin
            pin_meta_reg <= phys_id_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // physical id captured once after reset release
    always_ff @(posedge clock) begin
        if (rst) begin
            strap_wait_reg <= '0;
            strap_done_reg <= 1'b0;
            phys_id_reg    <= '0;
        end else if (clk_en && !strap_done_reg) begin
            if (strap_wait_reg == IPD_STRAP_WAIT) begin
                phys_id_reg    <= pin_sync_reg;
                strap_done_reg <= 1'b1;
            end else begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
            end
        end
    end

    // mode and logical id, reloaded on each entry to extended mode
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_reg <= IPD_MODE_LEGACY;
            ldr_reg  <= '0;
        end else if (clk_en) begin
            mode_reg <= mode_next;
            if (enter_ext)
                ldr_reg <= ipd_derive_ldr(phys_id_reg); // [RL16] [RL15] [RL14]
        end
    end

    // command register storage, 32-bit destination
    always_ff @(posedge clock) begin
        if (rst) begin
            icr_low_reg  <= '0;
            icr_dest_reg <= '0;
        end else if (clk_en) begin
            if (enter_ext)
                icr_dest_reg <= '0;
            else if (icr_write) begin
                icr_low_reg  <= wr_low;                      // [RL5]
                icr_dest_reg <= sr_wdata[63:32];             // [RL6]
            end
        end
    end

    // one-shot dispatch on a single command write
    always_ff @(posedge clock) begin
        if (rst) begin
            send_reg <= 1'b0;
            msg_reg  <= '0;
        end else if (clk_en) begin
            send_reg <= icr_write;                           // [RL7]
            if (icr_write) begin
                msg_reg.low       <= wr_low;
                msg_reg.dest      <= sr_wdata[63:32];        // [RL6]
                msg_reg.broadcast <= wr_bcast;               // [RL9]
            end
        end
    end

    // special register answer, one cycle after the request
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_reg <= '0;
            done_reg  <= 1'b0;
            fault_reg <= 1'b0;
        end else if (clk_en) begin
            done_reg  <= access;
            fault_reg <= access && bad_access;               // [RL10]
            if (sr_rd && !sr_wr && !bad_access)
                rdata_reg <= read_value;
            else if (access)
                rdata_reg <= '0;
        end
    end

    // identification answer, one cycle after the request
    always_ff @(posedge clock) begin
        if (rst) begin
            id_resp_reg  <= '0;
            id_valid_reg <= 1'b0;
        end else if (clk_en) begin
            id_valid_reg <= id_req;
            if (id_req)
                id_resp_reg <= id_answer;                    // [RL3]
        end
    end

    // destination check for incoming messages
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_done_reg   <= 1'b0;
            rx_accept_reg <= 1'b0;
        end else if (clk_en) begin
            rx_done_reg <= rx_valid;
            if (rx_valid)
                rx_accept_reg <= in_ext &&
                    (rx_bcast ||                             // [RL9]
                     (rx_logical ? rx_log_hit : rx_phys_hit)); // [RL20]
        end
    end

    // outputs straight from flops
    assign id_resp       = id_resp_reg;
    assign id_resp_valid = id_valid_reg;
    assign sr_rdata      = rdata_reg;
    assign sr_done       = done_reg;
    assign sr_fault      = fault_reg;
    assign ipi_send      = send_reg;
    assign ipi_msg       = msg_reg;
    assign rx_done       = rx_done_reg;
    assign rx_accept     = rx_accept_reg;
    assign mode_state    = mode_reg;
    assign phys_id_out   = phys_id_reg;

endmodule

/* tb/ipd_ipi_dest_asserts.sv */
`timescale 1ns/1ps
module ipd_ipi_dest_asserts
    import ipd_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // requests
    input  wire logic        id_req,
    input  wire logic [31:0] id_leaf,
    input  wire logic        sr_rd,
    input  wire logic        sr_wr,
    input  wire logic [31:0] sr_addr,
    input  wire logic [63:0] sr_wdata,
    input  wire logic        rx_valid,
    input  wire logic        rx_logical,
    input  wire logic [31:0] rx_dest,
    // answers
    input  ipd_id_resp_type  id_resp,
    input  wire logic        id_resp_valid,
    input  wire logic [63:0] sr_rdata,
    input  wire logic        sr_done,
    input  wire logic        sr_fault,
    input  wire logic        ipi_send,
    input  ipd_ipi_type      ipi_msg,
    input  wire logic        rx_done,
    input  wire logic        rx_accept,
    input  ipd_mode_type     mode_state,
    input  wire logic [31:0] phys_id_out
);
    // taken requests decoded once
    wire       ext_on = mode_state == IPD_MODE_EXT;
    wire       acc_go = clk_en && (sr_rd || sr_wr);
    wire       wr_icr = acc_go && sr_wr && sr_addr == IPD_ADDR_ICR && ext_on;
    wire       rd_hit = acc_go && !sr_wr && ext_on;
    wire       id_go  = clk_en && id_req;
    wire       rx_go  = clk_en && rx_valid;
    wire [7:0] pid_lo = phys_id_out[7:0];

    default clocking dc @(posedge clock); endclocking
    default disable iff (rst);

    sr_answer_a: assert property (acc_go |=> sr_done)
        else $error("access not answered");
    off_fault_a: assert property (acc_go && !ext_on |=> sr_fault)
        else $error("access outside extended mode not refused");
    one_write_a: assert property (wr_icr |=> ipi_send
        && ipi_msg.dest == $past(sr_wdata[63:32]))
        else $error("command write did not dispatch");
    send_cause_a: assert property (ipi_send |-> $past(wr_icr))
        else $error("dispatch without command write");
    bcast_flag_a: assert property (ipi_send |->
        ipi_msg.broadcast == (ipi_msg.dest == IPD_BROADCAST_ID))
        else $error("broadcast flag wrong");
    ldr_value_a: assert property (rd_hit && sr_addr == IPD_ADDR_LDR |=>
        sr_rdata == {32'h0, phys_id_out[19:4], 16'h1 << phys_id_out[3:0]})
        else $error("logical id read wrong");
    status_gone_a: assert property (rd_hit && sr_addr == IPD_ADDR_ICR
        |=> sr_rdata[12] == 1'b0)
        else $error("status bit seen in command read");
    feature_id_a: assert property (id_go && id_leaf == IPD_LEAF_FEATURE
        |=> id_resp_valid && id_resp.ecx[21]
        && id_resp.ebx[31:24] == $past(pid_lo))
        else $error("feature leaf answer wrong");
    topo_edx_a: assert property (id_go && id_leaf == IPD_LEAF_TOPO
        |=> id_resp.edx == $past(phys_id_out))
        else $error("topology id wrong");
    rx_legacy_a: assert property (rx_go && !ext_on
        |=> rx_done && !rx_accept)
        else $error("accept outside extended mode");
    rx_phys_a: assert property (rx_go && ext_on && !rx_logical
        && rx_dest == phys_id_out |=> rx_done && rx_accept)
        else $error("own physical id not accepted");
    rx_bcast_a: assert property (rx_go && ext_on
        && rx_dest == IPD_BROADCAST_ID |=> rx_accept)
        else $error("broadcast not accepted");
endmodule

bind ipd_ipi_dest ipd_ipi_dest_asserts i_ipd_ipi_dest_asserts (
    .clock, .rst, .clk_en, .id_req, .id_leaf, .sr_rd, .sr_wr, .sr_addr,
    .sr_wdata, .rx_valid, .rx_logical, .rx_dest, .id_resp, .id_resp_valid,
    .sr_rdata, .sr_done, .sr_fault, .ipi_send, .ipi_msg, .rx_done,
    .rx_accept, .mode_state, .phys_id_out
);

/* tb/ipd_ipi_dest_test.sv */
`timescale 1ns/1ps
module ipd_ipi_dest_test import ipd_pkg::*; ;
    // design side signals
    logic            clock, rst, clk_en, base_enable, base_extended;
    logic            id_req, sr_rd, sr_wr, rx_valid, rx_logical;
    logic [31:0]     phys_id_pin, id_leaf, id_subleaf, sr_addr, rx_dest;
    logic [63:0]     sr_wdata, sr_rdata, wv;
    ipd_id_resp_type id_resp;
    ipd_ipi_type     ipi_msg;
    ipd_mode_type    mode_state;
    logic            id_resp_valid, sr_done, sr_fault, ipi_send;
    logic            rx_done, rx_accept;
    logic [31:0]     phys_id_out, pid, logical_dest_id_reg, dst;
    int              error_cnt, check_count, i;
    integer          seed;

    ipd_ipi_dest i_ipd_ipi_dest (.clock, .rst, .clk_en, .base_enable,
        .base_extended, .phys_id_pin, .id_req, .id_leaf, .id_subleaf,
        .id_resp, .id_resp_valid, .sr_rd, .sr_wr, .sr_addr, .sr_wdata,
        .sr_rdata, .sr_done, .sr_fault, .ipi_send, .ipi_msg, .rx_valid,
        .rx_logical, .rx_dest, .rx_done, .rx_accept, .mode_state,
        .phys_id_out);

    // 200 mhz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // expected logical id from a physical id
    function automatic logic [31:0] ldr_of(logic [31:0] p);
        return {p[19:4], 16'h1 << p[3:0]};
    endfunction

    // expected acceptance in extended mode
    function automatic logic acc_of(logic lg, logic [31:0] d);
        if (d == IPD_BROADCAST_ID) return 1'b1;
        if (lg) return d[31:16] == logical_dest_id_reg[31:16] && (d[15:0] & logical_dest_id_reg[15:0]) != 0;
        return d == pid;
    endfunction

    task automatic report_and_stop();
        if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk_val(string n, logic [63:0] e, logic [63:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_flag(string n, logic e, logic g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s exp %b got %b", n, e, g);
        end
    endtask

    // one register access; the answer lands one enabled edge later
    task automatic sr_acc(logic rd, logic wr, logic [31:0] a, logic [63:0] d);
        @(posedge clock);
        sr_rd <= rd;
        sr_wr <= wr;
        sr_addr <= a;
        sr_wdata <= d;
        @(posedge clock);
        sr_rd <= 1'b0;
        sr_wr <= 1'b0;
        #1;
        chk_flag("sr_done", 1'b1, sr_done);
    endtask

    task automatic id_ask(logic [31:0] l, logic [31:0] s);
        @(posedge clock);
        id_req <= 1'b1;
        id_leaf <= l;
        id_subleaf <= s;
        @(posedge clock);
        id_req <= 1'b0;
        #1;
        chk_flag("id_valid", 1'b1, id_resp_valid);
    endtask

    task automatic rx_ask(logic lg, logic [31:0] d, logic e);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_logical <= lg;
        rx_dest <= d;
        @(posedge clock);
        rx_valid <= 1'b0;
        #1;
        chk_flag("rx_done", 1'b1, rx_done);
        chk_flag("rx_accept", e, rx_accept);
    endtask

    // hang guard
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        seed = 32'hccaf0b90;
        pid = $random(seed);
        logical_dest_id_reg = ldr_of(pid);
        phys_id_pin = pid;
        error_cnt = 0;
        check_count = 0;
        rst = 1'b1;
        clk_en = 1'b1;
        base_enable = 1'b1;
        base_extended = 1'b0;
        {id_req, sr_rd, sr_wr, rx_valid, rx_logical} = 5'h00;
        {id_leaf, id_subleaf, sr_addr, rx_dest} = 128'h0;
        sr_wdata = 64'h0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        // identification answers in legacy mode
        id_ask(IPD_LEAF_FEATURE, 32'h0);
        chk_flag("feature", 1'b1, id_resp.ecx[IPD_FEAT_EXT_BIT]);
        chk_val("init_id", pid[7:0], id_resp.ebx[31:24]);
        id_ask(IPD_LEAF_TOPO, 32'h0);
        chk_val("topo_edx", pid, id_resp.edx);
        chk_flag("topo_ebx", 1'b1, id_resp.ebx != 0);
        // second topology level answers with the core count
        id_ask(IPD_LEAF_TOPO, 32'h1);
        chk_val("topo_core", IPD_CORE_COUNT, id_resp.ebx);
        chk_val("topo_edx1", pid, id_resp.edx);
        id_ask(IPD_LEAF_MAX, 32'h0);
        chk_val("max_leaf", IPD_MAX_BASIC, id_resp.eax);
        // command write refused before extended mode
        sr_acc(1'b0, 1'b1, IPD_ADDR_ICR, {pid, 32'h0});
        chk_flag("legacy_fault", 1'b1, sr_fault);
        chk_flag("legacy_send", 1'b0, ipi_send);
        rx_ask(1'b0, pid, 1'b0);
        // enter extended mode, ids may reach 255 or more
        @(posedge clock);
        base_extended <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk_val("mode", IPD_MODE_EXT, mode_state);
        sr_acc(1'b1, 1'b0, IPD_ADDR_PHYS_ID, 64'h0);
        chk_val("phys_read", {32'h0, pid}, sr_rdata);
        chk_val("phys_out", pid, phys_id_out);
        sr_acc(1'b1, 1'b0, IPD_ADDR_LDR, 64'h0);
        chk_val("ldr_read", {32'h0, logical_dest_id_reg}, sr_rdata);
        sr_acc(1'b0, 1'b1, IPD_ADDR_LDR, 64'h0);
        chk_flag("ldr_ro", 1'b1, sr_fault);
        sr_acc(1'b1, 1'b0, IPD_ADDR_LDR + 32'h1, 64'h0);
        chk_flag("unmapped", 1'b1, sr_fault);
        // single command writes, broadcast first, each read back
        for (i = 0; i < 6; i++) begin
            dst = (i == 0) ? IPD_BROADCAST_ID : $random(seed);
            wv = {dst, 32'($random(seed))};
            sr_acc(1'b0, 1'b1, IPD_ADDR_ICR, wv);
            chk_flag("send", 1'b1, ipi_send);
            chk_val("dest", dst, ipi_msg.dest);
            chk_flag("bcast", i == 0, ipi_msg.broadcast);
            chk_val("low", wv[31:0] & IPD_ICR_LOW_MASK, ipi_msg.low);
            sr_acc(1'b1, 1'b0, IPD_ADDR_ICR, 64'h0);
            chk_val("icr", {dst, wv[31:0] & IPD_ICR_LOW_MASK}, sr_rdata);
        end
        // destination matching, odd passes logical
        for (i = 0; i < 16; i++) begin
            case (i / 2)
                0: dst = IPD_BROADCAST_ID;
                1: dst = i[0] ? logical_dest_id_reg : pid;
                2: dst = i[0] ? {logical_dest_id_reg[31:16] ^ 16'h1, logical_dest_id_reg[15:0]} : pid ^ 1;
                3: dst = i[0] ? {logical_dest_id_reg[31:16], ~logical_dest_id_reg[15:0]} : ~pid;
                default: dst = i[0] ? {logical_dest_id_reg[31:16], 16'($random(seed))}
                                    : $random(seed);
            endcase
            rx_ask(i[0], dst, acc_of(i[0], dst));
        end
        // leave, refuse, then re-enter and reload the logical id
        @(posedge clock);
        base_enable <= 1'b0;
        base_extended <= 1'b0;
        sr_acc(1'b1, 1'b0, IPD_ADDR_LDR, 64'h0);
        chk_flag("off_fault", 1'b1, sr_fault);
        @(posedge clock);
        base_enable <= 1'b1;
        repeat (2) @(posedge clock);
        base_extended <= 1'b1;
        repeat (2) @(posedge clock);
        sr_acc(1'b1, 1'b0, IPD_ADDR_LDR, 64'h0);
        chk_val("ldr_reload", {32'h0, logical_dest_id_reg}, sr_rdata);
        report_and_stop();
    end
endmodule
